// ===== hw/timer16_pkg.sv
// constants and carrier types for the sixteen-bit up-count timer
package timer16_pkg;
    localparam logic [7:0] timer_mode_offset     = 8'h06;
    localparam logic [7:0] edge_select_offset    = 8'h0c;
    localparam logic [7:0] intrq_offset          = 8'h05;
    localparam logic [7:0] mode_reset            = 8'h00;
    localparam logic [7:0] edge_reset            = 8'h00;
    localparam int         src_msb               = 7;
    localparam int         src_lsb               = 5;
    localparam int         pre_msb               = 4;
    localparam int         pre_lsb               = 3;
    localparam int         bitsel_msb            = 2;
    localparam int         bitsel_lsb            = 0;
    localparam int         edge_bit              = 4;
    localparam int         timer_irq_bit         = 2;
    localparam logic [3:0] irq_bit_base          = 4'h8;

    typedef enum logic [2:0] {
        src_stop   = 3'b000,
        src_sys    = 3'b001,
        src_res2   = 3'b010,
        src_res3   = 3'b011,
        src_fastrc = 3'b100,
        src_xtal   = 3'b101,
        src_slowrc = 3'b110,
        src_pin    = 3'b111
    } clk_src_e;

    // one cycle i/o access from the core
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } io_req_s;

    // dedicated timer store/read instruction strobes
    typedef struct packed {
        logic        store;
        logic        read;
        logic [15:0] store_data;
    } tmr_cmd_s;

    // raw clock sources, sampled on ref_clk
    typedef struct packed {
        logic fast_rc_clock;
        logic crystal_osc_clock;
        logic slow_rc_clock;
        logic external_count_pin;
    } clk_in_s;
endpackage : timer16_pkg

// ===== hw/timer16_tick_sel.sv
// source select and edge detect, producing one tick per rising source edge, or per falling edge for the pin
`timescale 1ns/100ps
module timer16_tick_sel
    import timer16_pkg::*;
(
    input  wire logic               ref_clk,
    input  wire logic               rst,
    input  wire timer16_pkg::clk_src_e src,
    input  wire timer16_pkg::clk_in_s  clk_in,
    output logic                    tick
);
    logic [3:0] prev_reg;
    logic       sel;

    // the sources are slower than ref_clk, so each edge is seen as one sample change
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            prev_reg <= 4'h0;
        else
            prev_reg <= clk_in;
    end

    always_comb
    begin
        case (src)
            src_sys:    sel = 1'b1;
            src_fastrc: sel = clk_in.fast_rc_clock & ~prev_reg[3];
            src_xtal:   sel = clk_in.crystal_osc_clock & ~prev_reg[2];
            src_slowrc: sel = clk_in.slow_rc_clock & ~prev_reg[1];
            src_pin:    sel = ~clk_in.external_count_pin & prev_reg[0];
            default:    sel = 1'b0;
        endcase
    end

    assign tick = sel;
endmodule : timer16_tick_sel

// ===== hw/timer16_prescale.sv
// divide-by 1/4/16/64 prescaler on source ticks
`timescale 1ns/100ps
module timer16_prescale
    import timer16_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic [1:0] div_sel,
    input  wire logic       tick_in,
    output logic            tick_out
);
    logic [5:0] cnt_reg;
    logic [5:0] limit;

    always_comb
    begin
        case (div_sel)
            2'b00:   limit = 6'h00;
            2'b01:   limit = 6'h03;
            2'b10:   limit = 6'h0f;
            default: limit = 6'h3f;
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            cnt_reg <= 6'h00;
        else if (tick_in)
            cnt_reg <= (cnt_reg >= limit) ? 6'h00 : cnt_reg + 6'h01;
    end

    assign tick_out = tick_in && (cnt_reg >= limit);
endmodule : timer16_prescale

// ===== hw/timer16_top.sv
// sixteen-bit up-count timer with mode, edge select and interrupt flag
`timescale 1ns/100ps
// What this block does
// - five clock sources through a multiplexer
// - prescaler divides by 1, 4, 16, 64
// - counter counts up by one per tick
// - store instruction loads counter from memory
// - read instruction returns count to memory
// - interrupt from counter bit 8 to 15
// - edge select bit 4 picks rising/falling
// - source field: stop, system, reserved, four sources
// - request every 2^(n+9) prescaled ticks
// - event sets request register bit 2
// - pin source counts falling pin edges
// - stop setting holds the counter
// - selected bit transition is the overflow
// - rate is source / prescale / 2^(n+9)
// - hardware sets flags, software write loads them
module timer16_top
    import timer16_pkg::*;
(
    input  wire logic                 ref_clk,
    input  wire logic                 rst,
    input  wire timer16_pkg::io_req_s  io_req,
    output logic [7:0]                io_rdata,
    input  wire timer16_pkg::tmr_cmd_s tmr_cmd,
    output logic [15:0]               count_rdata,
    output logic                      count_valid,
    input  wire timer16_pkg::clk_in_s  clk_in,
    output logic [7:0]                intrq,
    output logic                      timer_irq_pulse
);
    import timer16_pkg::*;

    logic [7:0]  mode_reg;
    logic [7:0]  edge_reg;
    logic [7:0]  intrq_reg;
    logic [15:0] count_reg;
    logic [15:0] count_rd_reg;
    logic        count_valid_reg;
    logic [7:0]  io_rdata_reg;
    logic [15:0] count_prev_reg;
    logic        mode_wr;
    logic        edge_wr;
    logic        intrq_wr;
    clk_src_e    src_code;
    logic [1:0]  div_code;
    logic [2:0]  bitsel_code;
    logic        falling_sel;
    logic        src_tick;
    logic        pre_tick;
    logic        sel_bit;
    logic        prev_bit;
    logic        irq_event;
    logic [3:0]  bit_idx;

    // address match shared by the register writes
    function automatic logic io_hit(input io_req_s req, input logic [7:0] offset);
        io_hit = (req.addr == offset);
    endfunction : io_hit

    function automatic logic [3:0] irq_bit_index(input logic [2:0] code);
        irq_bit_index = irq_bit_base + {1'b0, code};
    endfunction : irq_bit_index

    function automatic logic pick_bit(input logic [15:0] value, input logic [3:0] idx);
        pick_bit = value[idx];
    endfunction : pick_bit

    function automatic logic edge_seen(input logic prev, input logic cur, input logic falling);
        edge_seen = falling ? (prev & ~cur) : (~prev & cur);
    endfunction : edge_seen

    function automatic logic [7:0] read_value(input logic [7:0] addr,
                                              input logic [7:0] mode,
                                              input logic [7:0] edges,
                                              input logic [7:0] flags);
        case (addr)
            timer_mode_offset:  read_value = mode;
            edge_select_offset: read_value = edges;
            intrq_offset:       read_value = flags;
            default:            read_value = 8'h00;
        endcase
    endfunction : read_value

    assign mode_wr     = io_req.wr && io_hit(io_req, timer_mode_offset);
    assign edge_wr     = io_req.wr && io_hit(io_req, edge_select_offset);
    assign intrq_wr    = io_req.wr && io_hit(io_req, intrq_offset);
    assign src_code    = clk_src_e'(mode_reg[src_msb:src_lsb]);
    assign div_code    = mode_reg[pre_msb:pre_lsb];
    assign bitsel_code = mode_reg[bitsel_msb:bitsel_lsb];
    assign falling_sel = edge_reg[edge_bit];

    timer16_tick_sel u_sel (
        .ref_clk (ref_clk),
        .rst     (rst),
        .src     (src_code),
        .clk_in  (clk_in),
        .tick    (src_tick)
    );

    timer16_prescale u_pre (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .div_sel  (div_code),
        .tick_in  (src_tick),
        .tick_out (pre_tick)
    );

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            mode_reg <= mode_reset;
        else if (mode_wr)
            mode_reg <= io_req.wdata;
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            edge_reg <= edge_reset;
        else if (edge_wr)
            edge_reg <= io_req.wdata;
    end

    // store wins over counting in the same cycle
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            count_reg <= 16'h0000;
        else if (tmr_cmd.store)
            count_reg <= tmr_cmd.store_data;
        else if (pre_tick)
            count_reg <= count_reg + 16'h0001;
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            count_rd_reg    <= 16'h0000;
            count_valid_reg <= 1'b0;
        end
        else
        begin
            count_valid_reg <= tmr_cmd.read;
            if (tmr_cmd.read)
                count_rd_reg <= count_reg;
        end
    end

    assign bit_idx  = irq_bit_index(bitsel_code);
    assign sel_bit  = pick_bit(count_reg, bit_idx);
    assign prev_bit = pick_bit(count_prev_reg, bit_idx);

    // the whole previous count is kept, so moving the bit selection never fakes an edge
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            count_prev_reg <= 16'h0000;
        else
            count_prev_reg <= count_reg;
    end

    // a load can also make the bit toggle and is counted as an event too
    assign irq_event = edge_seen(prev_bit, sel_bit, falling_sel);

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            intrq_reg <= 8'h00;
        else
        begin
            if (intrq_wr)
                intrq_reg <= io_req.wdata;
            if (irq_event)
                intrq_reg[timer_irq_bit] <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            io_rdata_reg <= 8'h00;
        else if (io_req.rd)
            io_rdata_reg <= read_value(io_req.addr, mode_reg, edge_reg, intrq_reg);
    end

    assign io_rdata        = io_rdata_reg;
    assign count_rdata     = count_rd_reg;
    assign count_valid     = count_valid_reg;
    assign intrq           = intrq_reg;
    assign timer_irq_pulse = irq_event;
endmodule : timer16_top

// ===== verif/timer16_props.sv
// port checker for the timer block
`timescale 1ns/100ps
module timer16_props
    import timer16_pkg::*;
(
    input wire logic                  ref_clk,
    input wire logic                  rst,
    input wire timer16_pkg::io_req_s  io_req,
    input wire logic [7:0]            io_rdata,
    input wire timer16_pkg::tmr_cmd_s tmr_cmd,
    input wire logic [15:0]           count_rdata,
    input wire logic                  count_valid,
    input wire timer16_pkg::clk_in_s  clk_in,
    input wire logic [7:0]            intrq,
    input wire logic                  timer_irq_pulse
);
    logic wr_q;
    logic wr_m;
    logic rd_m;
    assign wr_q = io_req.wr && io_req.addr == intrq_offset;
    assign wr_m = io_req.wr && io_req.addr == timer_mode_offset;
    assign rd_m = io_req.rd && io_req.addr == timer_mode_offset;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    read_valid_a: assert property (tmr_cmd.read |=> count_valid)
        else $error("count valid missing");
    valid_cause_a: assert property (count_valid |-> $past(tmr_cmd.read))
        else $error("count valid without read");
    count_hold_a: assert property (!tmr_cmd.read |=> $stable(count_rdata))
        else $error("read count changed");
    irq_flag_a: assert property (timer_irq_pulse |=> intrq[2])
        else $error("timer flag not set");
    flag_hold_a: assert property (!timer_irq_pulse && !wr_q |=> intrq == $past(intrq))
        else $error("request flags changed");
    flag_write_a: assert property (wr_q && !timer_irq_pulse |=> intrq == $past(io_req.wdata))
        else $error("request write lost");
    pulse_once_a: assert property (timer_irq_pulse |=> !timer_irq_pulse)
        else $error("event pulse too long");
    mode_rb_a: assert property (wr_m ##2 rd_m |=> io_rdata == $past(io_req.wdata, 3))
        else $error("mode readback wrong");
endmodule : timer16_props
bind timer16_top timer16_props u_props (.ref_clk(ref_clk), .rst(rst), .io_req(io_req),
    .io_rdata(io_rdata), .tmr_cmd(tmr_cmd), .count_rdata(count_rdata),
    .count_valid(count_valid), .clk_in(clk_in), .intrq(intrq),
    .timer_irq_pulse(timer_irq_pulse));

// ===== verif/core_model.sv
// core model issuing i/o accesses and timer instructions
`timescale 1ns/100ps
module core_model
    import timer16_pkg::*;
(
    input  wire logic                  ref_clk,
    output timer16_pkg::io_req_s       io_req,
    output timer16_pkg::tmr_cmd_s      tmr_cmd,
    input  wire logic [7:0]            io_rdata,
    input  wire logic [15:0]           count_rdata,
    input  wire logic                  count_valid
);
    initial
    begin
        io_req = '0;
        tmr_cmd = '0;
    end
    // one-cycle strobe, idle cycle after; flags are cleared by a write or by reset
    task automatic io(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] r);
        @(negedge ref_clk);
        io_req = '{w, !w, a, d};
        @(negedge ref_clk);
        io_req = '0;
        r = io_rdata;
    endtask : io
    task automatic cmd(input logic s, input logic [15:0] v, output logic [15:0] r,
                       output logic ok);
        @(negedge ref_clk);
        tmr_cmd = '{s, !s, v};
        @(negedge ref_clk);
        tmr_cmd = '0;
        r = count_rdata;
        ok = count_valid;
    endtask : cmd
endmodule : core_model

// ===== verif/testbench.sv
// self-checking bench for the timer block
`timescale 1ns/100ps
module testbench;
    import timer16_pkg::*;
    logic                  ref_clk;
    logic                  rst;
    io_req_s               io_req;
    tmr_cmd_s              tmr_cmd;
    clk_in_s               clk_in;
    logic [7:0]            io_rdata;
    logic [7:0]            intrq;
    logic [7:0]            b;
    logic [15:0]           count_rdata;
    logic [15:0]           q;
    logic                  count_valid;
    logic                  ok;
    logic                  irq_pulse;
    int                    n_mismatch = 0;
    int                    total_checks = 0;
    timer16_top u_dut (.ref_clk(ref_clk), .rst(rst), .io_req(io_req), .io_rdata(io_rdata),
        .tmr_cmd(tmr_cmd), .count_rdata(count_rdata), .count_valid(count_valid),
        .clk_in(clk_in), .intrq(intrq), .timer_irq_pulse(irq_pulse));
    core_model u_core (.ref_clk(ref_clk), .io_req(io_req), .tmr_cmd(tmr_cmd),
        .io_rdata(io_rdata), .count_rdata(count_rdata), .count_valid(count_valid));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic results();
        $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : results
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_core.io(1'b1, a, d, b);
    endtask : wr
    task automatic st(input logic [15:0] v);
        u_core.cmd(1'b1, v, q, ok);
    endtask : st
    task automatic rc();
        u_core.cmd(1'b0, 16'h0000, q, ok);
        chk({15'h0000, ok}, 16'h0001);
    endtask : rc
    // levels held three cycles so the edge detector sees every level
    task automatic pulse(input int k, input int n);
        repeat (2 * n)
        begin
            repeat (3) @(negedge ref_clk);
            clk_in[k] = !clk_in[k];
        end
        repeat (4) @(negedge ref_clk);
    endtask : pulse
    task automatic t_regs();
        u_core.io(1'b0, timer_mode_offset, 8'h00, b);
        chk({8'h00, b}, {8'h00, mode_reset});
        wr(timer_mode_offset, 8'h1d);
        u_core.io(1'b0, timer_mode_offset, 8'h00, b);
        chk({8'h00, b}, 16'h001d);
        wr(intrq_offset, 8'ha0);
        u_core.io(1'b0, intrq_offset, 8'h00, b);
        chk({8'h00, b}, 16'h00a0);
        wr(edge_select_offset, 8'h10);
        u_core.io(1'b0, edge_select_offset, 8'h00, b);
        chk({8'h00, b}, 16'h0010);
        wr(edge_select_offset, 8'h00);
        $display("regs done");
    endtask : t_regs
    task automatic t_src();
        for (int c = 0; c < 8; c++)
        begin
            wr(timer_mode_offset, {3'(c), 5'h00});
            st(16'h00a0);
            pulse(c < 4 ? 0 : 7 - c, 3);
            rc();
            // the system source adds one per clock: 23 clocks pass from store to read
            chk(q, c == 1 ? 16'h00b7 : c < 4 ? 16'h00a0 : 16'h00a3);
        end
        $display("sources done");
    endtask : t_src
    task automatic t_pre();
        for (int p = 0; p < 4; p++)
        begin
            wr(timer_mode_offset, {3'b111, 2'(p), 3'b000});
            st(16'h0000);
            pulse(0, 2 << (2 * p));
            rc();
            chk(q, 16'h0002);
        end
        wr(timer_mode_offset, 8'he0);
        st(16'hfffe);
        pulse(0, 3);
        rc();
        chk(q, 16'h0001);
        $display("prescale done");
    endtask : t_pre
    // k = 0 makes the unselected transition, which must leave the flag clear
    task automatic t_irq();
        for (int e = 0; e < 2; e++)
            for (int n = 0; n < 8; n++)
                for (int k = 0; k < 2; k++)
                begin
                    wr(edge_select_offset, 8'(e << 4));
                    wr(timer_mode_offset, {5'b11100, 3'(n)});
                    st(e == k ? 16'hffff >> (7 - n) : 16'hffff >> (8 - n));
                    wr(intrq_offset, 8'h00);
                    chk({15'h0000, intrq[2]}, 16'h0000);
                    pulse(0, 1);
                    chk({15'h0000, intrq[2]}, 16'(k));
                end
        $display("interrupt done");
    endtask : t_irq
    // free run on the system source, bit 8, rising: events 512 clocks apart
    task automatic t_rate();
        int first;
        int n_seen;
        first = -1;
        n_seen = 0;
        wr(edge_select_offset, 8'h00);
        wr(timer_mode_offset, 8'h20);
        st(16'h0000);
        for (int i = 0; i < 1200 && n_seen < 2; i++)
        begin
            @(negedge ref_clk);
            if (irq_pulse === 1'b1)
            begin
                if (n_seen == 1)
                    chk(16'(i - first), 16'h0200);
                first = i;
                n_seen++;
            end
        end
        chk(16'(n_seen), 16'h0002);
        $display("rate done");
    endtask : t_rate
    // mid-run reset must clear the flags and return the source to stop
    task automatic t_rst();
        wr(intrq_offset, 8'hff);
        wr(timer_mode_offset, 8'h20);
        @(negedge ref_clk);
        rst = 1'b1;
        repeat (2) @(negedge ref_clk);
        rst = 1'b0;
        chk({8'h00, intrq}, 16'h0000);
        rc();
        chk(q, 16'h0000);
        $display("reset done");
    endtask : t_rst
    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    initial
    begin
        #2000000;
        n_mismatch++;
        results();
    end
    initial
    begin
        rst = 1'b1;
        clk_in = '0;
        repeat (4) @(negedge ref_clk);
        rst = 1'b0;
        t_regs();
        t_src();
        t_pre();
        t_irq();
        t_rate();
        t_rst();
        results();
    end
endmodule : testbench
